// *** ocpwm_pkg.sv ***
package ocpwm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTL_TWO = 8'h04;
  localparam logic [7:0] OFS_PRIMARY = 8'h08;
  localparam logic [7:0] OFS_SECONDARY = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_INT_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h20;

  // Mode field codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EDGE = 3'h6;
  localparam logic [2:0] MODE_CENTER = 3'h7;

  // Time base select codes
  localparam logic [2:0] TSEL_T2 = 3'h0;
  localparam logic [2:0] TSEL_T3 = 3'h1;
  localparam logic [2:0] TSEL_T4 = 3'h2;
  localparam logic [2:0] TSEL_T5 = 3'h3;
  localparam logic [2:0] TSEL_T1 = 3'h4;
  localparam logic [2:0] TSEL_PCLK = 3'h7;

  // Sync source code meaning this channel itself
  localparam logic [4:0] SYNC_SELF = 5'h1F;

  // Fault index: 0 first pin, 1 second pin, 2 comparator
  localparam int FLT_N = 3;

  // Interrupt status bit positions
  localparam int INT_FAULT = 0;
  localparam int INT_PERIOD = 1;
  localparam int INT_N = 2;

  // Reset values
  localparam logic [15:0] RST_CTL_ONE = 16'h0000;
  localparam logic [15:0] RST_CTL_TWO = 16'h000C;
  localparam logic [15:0] RST_VALUE = 16'h0000;

  typedef struct packed {
    logic [1:0] unused;
    logic idle_halt_bit;
    logic [2:0] time_base_select;
    logic [2:0] fault_input_enable;
    logic [2:0] fault_occurred_flag;
    logic trigger_clear_mode;
    logic [2:0] compare_mode_field;
  } ocpwm_ctl1_t;

  typedef struct packed {
    logic fault_hold_mode;
    logic fault_drive_level;
    logic [5:0] unused_hi;
    logic trigger_or_sync_select;
    logic [1:0] unused_lo;
    logic [4:0] sync_source_select;
  } ocpwm_ctl2_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ocpwm_bus_t;

endpackage : ocpwm_pkg

// *** ocpwm_sync3.sv ***
module ocpwm_sync3 #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs and filtered result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change is taken once the second and third stages agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_out <= '0;
    else
      sync_out <= (stage2 & ~(stage2 ^ stage3)) | (sync_out & (stage2 ^ stage3));
  end

endmodule : ocpwm_sync3

// *** ocpwm_channel.sv ***
// Notes on behaviour
// - Edge and center aligned PWM; duty values pass hidden shadow registers.
// - A selected timer contributes its prescaler tick, not its own output.
// - Period value N gives N plus one time base counts per period when the sync source is this channel itself.
// - In the two PWM modes, compare values move into shadows only at the period match.
// - All compare and period values zero keeps the output low.
// - Secondary value above period keeps the output high.
// - Top two control bits read zero; idle halt bit stops channel in idle.
// - Time base field picks timer two to five, timer one or peripheral clock.
// - Each fault source has its own enable; disabled sources are ignored.
// - Hardware sets fault status bits; software may read and write them.
// - Fault enables and status only act in the two PWM modes.
// - Comparator fault comes from the comparator serving the channel group.
// - A fault event raises the channel interrupt flag.
// - Mode seven is center aligned, six edge aligned, zero disabled.
// - Fault holds until source gone and new period with hold mode clear, or until software clear.
// - During a fault the output is driven to the fault drive level.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module ocpwm_channel #(
  parameter int CHANNEL = 1,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire ocpwm_pkg::ocpwm_bus_t bus_req,
  output logic [ocpwm_pkg::DATA_W-1:0] rdata,
  // Time base ticks: Timer2, Timer3, Timer4, Timer5, Timer1
  input wire logic [4:0] timer_ticks,
  input wire logic cpu_idle,
  // Fault sources
  input wire logic first_fault_pin,
  input wire logic second_fault_pin,
  input wire logic [2:0] comparator_out,
  // Outputs
  output logic compare_output_pin,
  output logic irq
);
  import ocpwm_pkg::*;

  localparam int CMP_IDX = (CHANNEL - 1) / 3;

  function automatic logic is_pwm(input logic [2:0] mode);
    is_pwm = (mode == MODE_EDGE) || (mode == MODE_CENTER);
  endfunction : is_pwm

  function automatic logic base_tick(input logic [2:0] sel, input logic [4:0] t);
    case (sel)
      TSEL_T2: base_tick = t[0];
      TSEL_T3: base_tick = t[1];
      TSEL_T4: base_tick = t[2];
      TSEL_T5: base_tick = t[3];
      TSEL_T1: base_tick = t[4];
      TSEL_PCLK: base_tick = 1'b1;
      default: base_tick = 1'b0;
    endcase
  endfunction : base_tick

  ocpwm_ctl1_t ctl1;
  ocpwm_ctl2_t ctl2;
  logic [CNT_W-1:0] primary_compare_value;
  logic [CNT_W-1:0] secondary_compare_value;
  logic [CNT_W-1:0] timer_period_value;
  logic [CNT_W-1:0] primary_shadow;
  logic [CNT_W-1:0] secondary_shadow;
  logic [CNT_W-1:0] timer_count_value;
  logic [FLT_N-1:0] fault_flag;
  logic [INT_N-1:0] int_status;
  logic [INT_N-1:0] int_enable;
  logic [FLT_N-1:0] fault_sync;

  logic wr_ctl1;
  logic pwm_mode;
  logic running;
  logic tick;
  logic match;
  logic self_sync;
  logic [FLT_N-1:0] fault_live;
  logic fault_event;
  logic faulted;
  logic next_out;
  logic [DATA_W-1:0] next_rdata;

  ocpwm_sync3 #(
    .W(FLT_N)
  ) u_fault_sync (
    .clk(clk),
    .rst(rst),
    .async_in({comparator_out[CMP_IDX], second_fault_pin, first_fault_pin}),
    .sync_out(fault_sync)
  );

  assign wr_ctl1 = bus_req.wr && (bus_req.addr == OFS_CTL_ONE);
  assign pwm_mode = is_pwm(ctl1.compare_mode_field);
  assign running = pwm_mode && !(cpu_idle && ctl1.idle_halt_bit);
  assign tick = running && base_tick(ctl1.time_base_select, timer_ticks);
  assign match = tick && (timer_count_value == timer_period_value);
  assign self_sync = (ctl2.sync_source_select == SYNC_SELF) && !ctl2.trigger_or_sync_select;
  assign fault_live = fault_sync & ctl1.fault_input_enable & {FLT_N{pwm_mode}};
  assign fault_event = |(fault_live & ~fault_flag);
  assign faulted = pwm_mode && (|fault_flag);

  // Control registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctl1 <= RST_CTL_ONE;
      ctl2 <= RST_CTL_TWO;
    end
    else
    begin
      if (wr_ctl1)
      begin
        ctl1.idle_halt_bit <= bus_req.wdata[13];
        ctl1.time_base_select <= bus_req.wdata[12:10];
        ctl1.fault_input_enable <= bus_req.wdata[9:7];
        ctl1.trigger_clear_mode <= bus_req.wdata[3];
        ctl1.compare_mode_field <= bus_req.wdata[2:0];
      end
      ctl1.unused <= 2'h0;
      ctl1.fault_occurred_flag <= 3'h0;
      if (bus_req.wr && (bus_req.addr == OFS_CTL_TWO))
      begin
        ctl2.fault_hold_mode <= bus_req.wdata[15];
        ctl2.fault_drive_level <= bus_req.wdata[14];
        ctl2.trigger_or_sync_select <= bus_req.wdata[7];
        ctl2.sync_source_select <= bus_req.wdata[4:0];
      end
      ctl2.unused_hi <= 6'h00;
      ctl2.unused_lo <= 2'h0;
    end
  end

  // Software visible compare and period values, writable at any time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      primary_compare_value <= RST_VALUE[CNT_W-1:0];
      secondary_compare_value <= RST_VALUE[CNT_W-1:0];
      timer_period_value <= RST_VALUE[CNT_W-1:0];
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == OFS_PRIMARY)
        primary_compare_value <= bus_req.wdata[CNT_W-1:0];
      if (bus_req.addr == OFS_SECONDARY)
        secondary_compare_value <= bus_req.wdata[CNT_W-1:0];
      if (bus_req.addr == OFS_PERIOD)
        timer_period_value <= bus_req.wdata[CNT_W-1:0];
    end
  end

  // Shadows follow while disabled so the first period uses fresh values
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      primary_shadow <= RST_VALUE[CNT_W-1:0];
      secondary_shadow <= RST_VALUE[CNT_W-1:0];
    end
    else if (match || !pwm_mode)
    begin
      primary_shadow <= primary_compare_value;
      secondary_shadow <= secondary_compare_value;
    end
  end

  // Channel counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_count_value <= RST_VALUE[CNT_W-1:0];
    else if (!pwm_mode)
      timer_count_value <= '0;
    else if (match && self_sync)
      timer_count_value <= '0;
    else if (tick)
      timer_count_value <= timer_count_value + 1'b1;
  end

  // Fault flags: a live fault wins over any clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fault_flag <= '0;
    else
    begin
      for (int i = 0; i < FLT_N; i++)
      begin
        if (fault_live[i])
          fault_flag[i] <= 1'b1;
        else if (wr_ctl1)
          fault_flag[i] <= bus_req.wdata[4 + i];
        else if (!ctl2.fault_hold_mode && match)
          fault_flag[i] <= 1'b0;
      end
    end
  end

  // Output waveform
  always_comb
  begin
    next_out = 1'b0;
    if (ctl1.compare_mode_field == MODE_CENTER)
      next_out = (timer_count_value >= primary_shadow) && (timer_count_value < secondary_shadow);
    else if (ctl1.compare_mode_field == MODE_EDGE)
      next_out = timer_count_value < primary_shadow;
    if (pwm_mode && (secondary_shadow > timer_period_value))
      next_out = 1'b1;
    if (faulted)
      next_out = ctl2.fault_drive_level;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      compare_output_pin <= 1'b0;
    else
      compare_output_pin <= next_out;
  end

  // Interrupt status, enable and clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_status <= '0;
      int_enable <= '0;
    end
    else
    begin
      if (bus_req.wr && (bus_req.addr == OFS_INT_ENABLE))
        int_enable <= bus_req.wdata[INT_N-1:0];
      for (int i = 0; i < INT_N; i++)
      begin
        if ((i == INT_FAULT) ? fault_event : match)
          int_status[i] <= 1'b1;
        else if (bus_req.wr && (bus_req.addr == OFS_INT_CLEAR) && bus_req.wdata[i])
          int_status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_enable);
  end

  // Read data, valid only in the cycle after the read strobe
  always_comb
  begin
    next_rdata = '0;
    case (bus_req.addr)
      OFS_CTL_ONE: next_rdata = {ctl1[15:7], fault_flag, ctl1[3:0]};
      OFS_CTL_TWO: next_rdata = ctl2;
      OFS_PRIMARY: next_rdata[CNT_W-1:0] = primary_compare_value;
      OFS_SECONDARY: next_rdata[CNT_W-1:0] = secondary_compare_value;
      OFS_PERIOD: next_rdata[CNT_W-1:0] = timer_period_value;
      OFS_COUNT: next_rdata[CNT_W-1:0] = timer_count_value;
      OFS_INT_STATUS: next_rdata[INT_N-1:0] = int_status;
      OFS_INT_ENABLE: next_rdata[INT_N-1:0] = int_enable;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= '0;
    else if (bus_req.rd)
      rdata <= next_rdata;
    else
      rdata <= '0;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_period_match;
    match && !faulted;
  endsequence

  sequence seq_new_fault;
    fault_event;
  endsequence

  a_zero_duty_low: assert property (
    (pwm_mode && !faulted && primary_shadow == 0 && secondary_shadow == 0 && timer_period_value == 0)
    |=> !compare_output_pin)
    else $error("output not low with all values zero");

  a_full_duty_high: assert property (
    (pwm_mode && !faulted && secondary_shadow > timer_period_value) |=> compare_output_pin)
    else $error("output not high with secondary above period");

  a_shadow_at_match: assert property (
    seq_period_match |=> (primary_shadow == $past(primary_compare_value))
    && (secondary_shadow == $past(secondary_compare_value)))
    else $error("shadows not loaded at period match");

  a_shadow_holds: assert property (
    (pwm_mode && !match) |=> $stable(primary_shadow) && $stable(secondary_shadow))
    else $error("shadow changed inside a period");

  a_count_restart: assert property (
    (match && self_sync) |=> timer_count_value == 0)
    else $error("counter not restarted at period match");

  a_count_step: assert property (
    (tick && !match && pwm_mode) |=> timer_count_value == $past(timer_count_value) + 1'b1)
    else $error("counter did not advance on a tick");

  a_idle_halt: assert property (
    (cpu_idle && ctl1.idle_halt_bit) |=> $stable(timer_count_value))
    else $error("counter ran while halted in idle");

  a_fault_drive: assert property (
    faulted |=> compare_output_pin == $past(ctl2.fault_drive_level))
    else $error("output not at fault level");

  a_fault_ignored: assert property (
    (!pwm_mode && !wr_ctl1) |=> $stable(fault_flag))
    else $error("fault status changed outside pwm mode");

  a_fault_irq: assert property (
    seq_new_fault |=> int_status[INT_FAULT] ##1 (irq || !$past(int_enable[INT_FAULT])))
    else $error("fault did not raise interrupt");

  a_reserved_zero: assert property (
    (bus_req.rd && bus_req.addr == OFS_CTL_ONE) |=> rdata[15:14] == 2'h0)
    else $error("reserved control bits not zero");

endmodule : ocpwm_channel

// *** ocpwm_load.sv ***
module ocpwm_load (
  // Clock and drive from the channel
  input wire logic clk,
  input wire logic pin,
  // Bench commands
  input wire logic trip,
  input wire logic clr,
  // Sense outputs
  output logic fault,
  output int high_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  // Overcurrent sense follows the commanded trip level
  assign fault = trip;

  // High-time counter, so duty is judged over whole periods
  always_ff @(posedge clk)
  begin
    if (clr)
      high_cnt <= 0;
    else
      high_cnt <= high_cnt + int'(pin);
  end
endmodule : ocpwm_load

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ocpwm_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  ocpwm_bus_t bus = '0;
  logic [15:0] rdata;
  logic [4:0] timer_ticks = 5'h00;
  logic [4:0] sel_mask = 5'h1F;
  logic ph = 1'b0;
  logic cpu_idle = 1'b0;
  logic trip = 1'b0;
  logic clr = 1'b0;
  logic second_pin = 1'b0;
  logic [2:0] cmp = 3'h0;
  logic fault;
  logic pin;
  logic irq;
  int high_cnt;
  int bad_count = 0;
  int check_count = 0;
  logic [15:0] v;
  logic [15:0] w;

  always #25 clk = ~clk;

  // Prescaler ticks at half rate, only on the timers in sel_mask
  always @(posedge clk)
  begin
    ph <= ~ph;
    timer_ticks <= ph ? sel_mask : 5'h00;
  end

  ocpwm_channel u_ocpwm_channel (.clk(clk), .rst(rst), .bus_req(bus), .rdata(rdata),
    .timer_ticks(timer_ticks), .cpu_idle(cpu_idle), .first_fault_pin(fault),
    .second_fault_pin(second_pin), .comparator_out(cmp), .compare_output_pin(pin), .irq(irq));

  ocpwm_load u_ocpwm_load (.clk(clk), .pin(pin), .trip(trip), .clr(clr), .fault(fault),
    .high_cnt(high_cnt));

  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    // Read data stand for the one cycle after the strobe; taken at its closing edge
    @(posedge clk);
    d = rdata;
  endtask : rd

  task rchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask : rchk

  // Lets old periods drain, then counts high cycles over n clocks
  task meas(input int n, input int exp);
    repeat (8) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1 chk(16'(high_cnt), 16'(exp));
  endtask : meas

  task wait_irq;
    int k;
    for (k = 0; k < 40 && irq !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, irq}, 16'h0001);
    if (irq !== 1'b1)
      close_out;
  endtask : wait_irq

  // Count frozen: two reads of the counter agree
  task frozen;
    rd(OFS_COUNT, v);
    repeat (6) @(posedge clk);
    rd(OFS_COUNT, w);
    chk(w, v);
  endtask : frozen

  task t_reset;
    rchk(OFS_CTL_ONE, 16'h0000);
    rchk(OFS_CTL_TWO, 16'h000C);
    rchk(8'h24, 16'h0000);
    wr(OFS_CTL_ONE, 16'hFFFF);
    rchk(OFS_CTL_ONE, 16'h3F8F);
    wr(OFS_CTL_ONE, 16'h0000);
  endtask : t_reset

  task t_edge;
    wr(OFS_CTL_TWO, 16'h001F);
    wr(OFS_PERIOD, 16'h0003);
    wr(OFS_PRIMARY, 16'h0002);
    wr(OFS_SECONDARY, 16'h0003);
    wr(OFS_CTL_ONE, 16'h1C06);
    meas(16, 8);
    wr(OFS_PRIMARY, 16'h0001);
    meas(16, 4);
    wr(OFS_SECONDARY, 16'h0005);
    meas(8, 8);
    wr(OFS_SECONDARY, 16'h0003);
    wr(OFS_CTL_ONE, 16'h1C07);
    meas(16, 8);
  endtask : t_edge

  task t_tsel;
    wr(OFS_PRIMARY, 16'h0002);
    for (int i = 0; i < 5; i++)
    begin
      sel_mask <= 5'h01 << i;
      wr(OFS_CTL_ONE, {3'h0, i[2:0], 10'h006});
      meas(16, 8);
    end
    sel_mask <= 5'h1F;
    wr(OFS_CTL_ONE, 16'h1406);
    frozen;
    wr(OFS_CTL_ONE, 16'h3C06);
    cpu_idle <= 1'b1;
    frozen;
    cpu_idle <= 1'b0;
  endtask : t_tsel

  task t_zero;
    // Values loaded while disabled, so a stale count cannot run past a zero period
    wr(OFS_CTL_ONE, 16'h0000);
    wr(OFS_PRIMARY, 16'h0000);
    wr(OFS_SECONDARY, 16'h0000);
    wr(OFS_PERIOD, 16'h0000);
    wr(OFS_CTL_ONE, 16'h1C06);
    meas(8, 0);
    wr(OFS_PERIOD, 16'h0003);
    wr(OFS_PRIMARY, 16'h0002);
    wr(OFS_SECONDARY, 16'h0003);
  endtask : t_zero

  task t_fault;
    wr(OFS_CTL_TWO, 16'h401F);
    wr(OFS_INT_ENABLE, 16'h0001);
    wr(OFS_CTL_ONE, 16'h1C86);
    second_pin <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(OFS_CTL_ONE, 16'h1C86);
    second_pin <= 1'b0;
    trip <= 1'b1;
    wait_irq;
    meas(8, 8);
    rchk(OFS_CTL_ONE, 16'h1C96);
    trip <= 1'b0;
    repeat (12) @(posedge clk);
    rchk(OFS_CTL_ONE, 16'h1C86);
    // Hold mode set: the flag survives the end of the fault until software clears it
    wr(OFS_CTL_TWO, 16'hC01F);
    trip <= 1'b1;
    repeat (10) @(posedge clk);
    trip <= 1'b0;
    repeat (12) @(posedge clk);
    rchk(OFS_CTL_ONE, 16'h1C96);
    wr(OFS_CTL_ONE, 16'h1C86);
    rchk(OFS_CTL_ONE, 16'h1C86);
    wr(OFS_INT_CLEAR, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    rchk(OFS_INT_STATUS, 16'h0002);
  endtask : t_fault

  task t_cmp;
    wr(OFS_CTL_ONE, 16'h1E06);
    cmp <= 3'b110;
    repeat (10) @(posedge clk);
    rchk(OFS_CTL_ONE, 16'h1E06);
    cmp <= 3'b001;
    repeat (10) @(posedge clk);
    rchk(OFS_CTL_ONE, 16'h1E46);
    cmp <= 3'b000;
    repeat (12) @(posedge clk);
    wr(OFS_CTL_ONE, 16'h0080);
    trip <= 1'b1;
    repeat (10) @(posedge clk);
    rchk(OFS_CTL_ONE, 16'h0080);
    trip <= 1'b0;
  endtask : t_cmp

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_edge;
    t_tsel;
    t_zero;
    t_fault;
    t_cmp;
    close_out;
  end
endmodule : tb_top
